// ### logic/upr_baud_cnt.v
`timescale 1ns/1ns
`include "upr_defs.vh"

// Half-bit tick generator; a full bit is two ticks.
module upr_baud_cnt #(
  parameter W = 8
) (
  input wire clk, // Base clock.
  input wire rst_n, // Synchronous reset, active low.
  input wire clr, // Restart the count from zero.
  input wire run, // Count while high.
  input wire [W-1:0] divisor, // Clocks per half bit.
  output wire tick // One-cycle pulse each divisor clocks, every two clocks for a divisor below two.
);

  reg [W-1:0] cnt_r;
  wire [W-1:0] div_eff;

  // A divisor of 1 would tick every cycle and break the half-bit split; 0 would wrap.
  assign div_eff = (divisor < `UPR_DIV_MIN) ? `UPR_DIV_MIN : divisor;
  assign tick = run && !clr && (cnt_r == div_eff - {{(W-1){1'b0}}, 1'b1});

  always @(posedge clk) begin
    if (!rst_n || clr || !run) begin
      cnt_r <= {W{1'b0}};
    end else if (tick) begin
      cnt_r <= {W{1'b0}};
    end else begin
      cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule // upr_baud_cnt

// ### logic/upr_defs.vh
`ifndef UPR_DEFS_VH
`define UPR_DEFS_VH

// ----------------------------------------------------------------------------
// Register byte offsets on the Avalon-MM slave
// ----------------------------------------------------------------------------
`define UPR_OFS_MODE 5'h00
`define UPR_OFS_ERRSTAT 5'h04
`define UPR_OFS_TXSTAT 5'h08
`define UPR_OFS_TXBUF 5'h0C
`define UPR_OFS_RXBUF 5'h10
`define UPR_OFS_DIVISOR 5'h14

// ----------------------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------------------
`define UPR_MODE_POWER 7
`define UPR_MODE_TXE 6
`define UPR_MODE_RXE 5
`define UPR_MODE_PS_HI 4
`define UPR_MODE_PS_LO 3
`define UPR_MODE_CL8 2
`define UPR_MODE_SL2 1
`define UPR_MODE_ISRM 0

// Parity select codes, {parity_select_high, parity_select_low}.
`define UPR_PAR_NONE 2'h0
`define UPR_PAR_ZERO 2'h1
`define UPR_PAR_ODD 2'h2
`define UPR_PAR_EVEN 2'h3

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define UPR_TXST_FULL 1
`define UPR_TXST_ACTIVE 0
`define UPR_ERR_OVERRUN 0
`define UPR_ERR_FRAMING 1
`define UPR_ERR_PARITY 2

// ----------------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------------
`define UPR_MODE_RST 8'h00
`define UPR_DIV_RST 8'h10
`define UPR_DIV_MIN 8'h02
`define UPR_RXBUF_RST 8'hFF
`define UPR_FRAME_IDLE 12'hFFF

`endif

// ### logic/upr_path.v
`timescale 1ns/1ns
`include "upr_defs.vh"

// Notes on behaviour
// - Even parity: tx parity makes ones even.
// - Even parity: odd receive count flags error.
// - Odd parity: tx parity makes ones odd.
// - Odd parity: even receive count flags error.
// - Zero parity: send 0, never check.
// - No parity: no bit, no error.
// - Buffer write after power, enable starts frame.
// - Tx done pulse right after last stop.
// - No pending byte: transmitter stays idle.
// - Buffer refillable once shifting has begun.
// - Status bit 1 is buffer full.
// - Status bit 0 is shift active.
// - Continuous flags go 10, 01, 11, 01.
// - Power then receive enable starts sampling.
// - Falling edge, count divisor, recheck low.
// - Shift bits, stop: irq, store unless overrun.
// - Parity error does not abort frame.
// - Receiver checks only one stop bit.
// - Reading error status clears its flags.
// - Framing on missing stop; overrun on unread.
// - Merge bit routes errors to irq.
module upr_path #(
  parameter DIV_W = 8
) (
  input wire clk, // Base clock, 25 MHz.
  input wire rst_n, // Synchronous reset, active low.
  input wire [4:0] avs_address, // Byte address.
  input wire avs_read, // Read request.
  input wire avs_write, // Write request.
  input wire [31:0] avs_writedata, // Write data.
  output reg [31:0] avs_readdata, // Read data.
  output reg avs_waitrequest, // Stall, high until the access edge.
  input wire serial_in_pin, // Receive line.
  output reg serial_out_pin, // Transmit line.
  output reg tx_done_irq, // Transmit completion pulse.
  output reg rx_done_irq, // Receive completion pulse.
  output reg rx_error_irq // Receive error pulse.
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  localparam RX_IDLE = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_DATA = 2'h2;
  localparam RX_STOP = 2'h3;

  function par_bit;
    input [7:0] data;
    input len8;
    input [1:0] psel;
    reg ones;
    begin
      ones = ^(len8 ? data : {1'b0, data[6:0]});
      case (psel)
        `UPR_PAR_EVEN: par_bit = ones;
        `UPR_PAR_ODD: par_bit = ~ones;
        default: par_bit = 1'b0;
      endcase
    end
  endfunction

  function [3:0] data_bits;
    input len8;
    begin
      data_bits = len8 ? 4'h8 : 4'h7;
    end
  endfunction

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg [7:0] operation_mode_reg_r;
  reg [DIV_W-1:0] baud_divisor_reg_r;
  reg [2:0] receive_error_status_r;
  reg [2:0] err_nxt;
  reg [7:0] transmit_buffer_r;
  reg tx_buffer_full_r;
  reg tx_shift_active_r;
  reg [11:0] transmit_shifter_r;
  reg [3:0] tx_idx_r;
  reg tx_half_r;
  reg [1:0] rx_state_r;
  reg rx_prev_r;
  reg [7:0] receive_shifter_r;
  reg [3:0] rx_idx_r;
  reg rx_half_r;
  reg rx_ones_r;
  reg [7:0] receive_buffer_r;
  reg rx_full_r;
  reg rx_snap_r;

  wire power_on = operation_mode_reg_r[`UPR_MODE_POWER];
  wire tx_en = power_on && operation_mode_reg_r[`UPR_MODE_TXE];
  wire rx_en = power_on && operation_mode_reg_r[`UPR_MODE_RXE];
  wire [1:0] psel = {operation_mode_reg_r[`UPR_MODE_PS_HI], operation_mode_reg_r[`UPR_MODE_PS_LO]};
  wire len8 = operation_mode_reg_r[`UPR_MODE_CL8];
  wire stop2 = operation_mode_reg_r[`UPR_MODE_SL2];
  wire merge_err = operation_mode_reg_r[`UPR_MODE_ISRM];
  wire par_on = (psel != `UPR_PAR_NONE);

  // --------------------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, the access takes effect at the edge
  // where waitrequest is low.
  // --------------------------------------------------------------------------
  wire req = avs_read || avs_write;
  wire acc = req && !avs_waitrequest;
  wire wr_acc = acc && avs_write;
  wire rd_acc = acc && avs_read;
  wire wr_mode = wr_acc && (avs_address == `UPR_OFS_MODE);
  wire wr_div = wr_acc && (avs_address == `UPR_OFS_DIVISOR);
  wire wr_txbuf = wr_acc && (avs_address == `UPR_OFS_TXBUF);
  wire rd_err = rd_acc && (avs_address == `UPR_OFS_ERRSTAT);
  wire rd_rxbuf = rd_acc && (avs_address == `UPR_OFS_RXBUF);

  reg [31:0] rdata_nxt;

  always @* begin
    rdata_nxt = 32'h00000000;
    case (avs_address)
      `UPR_OFS_MODE: rdata_nxt[7:0] = operation_mode_reg_r;
      `UPR_OFS_ERRSTAT: rdata_nxt[2:0] = receive_error_status_r;
      `UPR_OFS_TXSTAT: rdata_nxt[1:0] = {tx_buffer_full_r, tx_shift_active_r};
      `UPR_OFS_RXBUF: rdata_nxt[7:0] = receive_buffer_r;
      `UPR_OFS_DIVISOR: rdata_nxt[DIV_W-1:0] = baud_divisor_reg_r;
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      rx_snap_r <= 1'b0;
    end else begin
      avs_waitrequest <= avs_waitrequest ? !req : 1'b1;
      if (req && avs_waitrequest) begin
        avs_readdata <= rdata_nxt;
        rx_snap_r <= rx_full_r;
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      operation_mode_reg_r <= `UPR_MODE_RST;
      baud_divisor_reg_r <= `UPR_DIV_RST;
    end else begin
      if (wr_mode) begin
        operation_mode_reg_r <= avs_writedata[7:0];
      end
      if (wr_div) begin
        baud_divisor_reg_r <= avs_writedata[DIV_W-1:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Baud counters, one per direction
  // --------------------------------------------------------------------------
  wire tx_tick;
  wire rx_tick;
  wire tx_load = tx_en && tx_buffer_full_r && !tx_shift_active_r;
  wire rx_fall = rx_en && (rx_state_r == RX_IDLE) && rx_prev_r && !serial_in_pin;

  upr_baud_cnt #(.W(DIV_W)) u_tx_cnt (
    .clk(clk),
    .rst_n(rst_n),
    .clr(tx_load),
    .run(tx_en),
    .divisor(baud_divisor_reg_r),
    .tick(tx_tick)
  );

  upr_baud_cnt #(.W(DIV_W)) u_rx_cnt (
    .clk(clk),
    .rst_n(rst_n),
    .clr(rx_fall),
    .run(rx_en && (rx_state_r != RX_IDLE || rx_fall)),
    .divisor(baud_divisor_reg_r),
    .tick(rx_tick)
  );

  // --------------------------------------------------------------------------
  // Transmitter
  // --------------------------------------------------------------------------
  // Index of the last stop bit: start, data, parity if any, then one or two stops.
  wire [3:0] tx_last = data_bits(len8) + {3'h0, par_on} + 4'h1 + {3'h0, stop2};
  wire tx_bit_end = tx_shift_active_r && tx_tick && tx_half_r;
  wire tx_frame_end = tx_bit_end && (tx_idx_r == tx_last);

  reg [11:0] frame_nxt;

  always @* begin
    frame_nxt = `UPR_FRAME_IDLE;
    frame_nxt[0] = 1'b0;
    if (len8) begin
      frame_nxt[8:1] = transmit_buffer_r;
      frame_nxt[9] = par_on ? par_bit(transmit_buffer_r, len8, psel) : 1'b1;
    end else begin
      frame_nxt[7:1] = transmit_buffer_r[6:0];
      frame_nxt[8] = par_on ? par_bit(transmit_buffer_r, len8, psel) : 1'b1;
    end
  end

  // Disabling the transmitter resets it in step with the clock.
  always @(posedge clk) begin
    if (!rst_n || !tx_en) begin
      tx_buffer_full_r <= 1'b0;
      tx_shift_active_r <= 1'b0;
      transmit_shifter_r <= `UPR_FRAME_IDLE;
      tx_idx_r <= 4'h0;
      tx_half_r <= 1'b0;
      serial_out_pin <= 1'b1;
      tx_done_irq <= 1'b0;
    end else begin
      tx_done_irq <= tx_frame_end;
      // A write while full overwrites the pending byte; software is told not to.
      if (wr_txbuf) begin
        transmit_buffer_r <= avs_writedata[7:0];
        tx_buffer_full_r <= 1'b1;
      end else if (tx_load) begin
        tx_buffer_full_r <= 1'b0;
      end
      if (tx_load) begin
        transmit_shifter_r <= frame_nxt;
        tx_shift_active_r <= 1'b1;
        tx_idx_r <= 4'h0;
        tx_half_r <= 1'b0;
        serial_out_pin <= 1'b0;
      end else if (tx_frame_end) begin
        tx_shift_active_r <= 1'b0;
        serial_out_pin <= 1'b1;
      end else if (tx_bit_end) begin
        transmit_shifter_r <= {1'b1, transmit_shifter_r[11:1]};
        serial_out_pin <= transmit_shifter_r[1];
        tx_idx_r <= tx_idx_r + 4'h1;
        tx_half_r <= 1'b0;
      end else if (tx_shift_active_r && tx_tick) begin
        tx_half_r <= 1'b1;
      end else if (!tx_shift_active_r) begin
        serial_out_pin <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Receiver
  // --------------------------------------------------------------------------
  wire rx_mid = rx_tick && rx_half_r;
  wire [3:0] rx_last = data_bits(len8) + {3'h0, par_on} - 4'h1;
  wire rx_stop_seen = (rx_state_r == RX_STOP) && rx_mid;
  wire pe_now = ((psel == `UPR_PAR_EVEN) && rx_ones_r) || ((psel == `UPR_PAR_ODD) && !rx_ones_r);
  wire fe_now = !serial_in_pin;
  wire ove_now = rx_full_r;
  wire any_err = pe_now || fe_now || ove_now;
  wire rx_store = rx_stop_seen && !ove_now;

  always @* begin
    err_nxt = receive_error_status_r;
    if (rd_err) begin
      err_nxt = err_nxt & ~avs_readdata[2:0];
    end
    if (rx_stop_seen) begin
      err_nxt[`UPR_ERR_PARITY] = err_nxt[`UPR_ERR_PARITY] | pe_now;
      err_nxt[`UPR_ERR_FRAMING] = err_nxt[`UPR_ERR_FRAMING] | fe_now;
      err_nxt[`UPR_ERR_OVERRUN] = err_nxt[`UPR_ERR_OVERRUN] | ove_now;
    end
  end

  // Power off clears the error flags; a rebuild of the receiver alone does not.
  always @(posedge clk) begin
    if (!rst_n || !power_on) begin
      receive_error_status_r <= 3'h0;
    end else begin
      receive_error_status_r <= err_nxt;
    end
  end

  always @(posedge clk) begin
    if (!rst_n || !power_on) begin
      receive_buffer_r <= `UPR_RXBUF_RST;
      rx_full_r <= 1'b0;
    end else if (rx_store) begin
      receive_buffer_r <= len8 ? receive_shifter_r : {1'b0, receive_shifter_r[7:1]};
      rx_full_r <= 1'b1;
    end else if (rd_rxbuf && rx_snap_r) begin
      rx_full_r <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (!rst_n || !rx_en) begin
      rx_state_r <= RX_IDLE;
      rx_prev_r <= 1'b1;
      receive_shifter_r <= 8'h00;
      rx_idx_r <= 4'h0;
      rx_half_r <= 1'b0;
      rx_ones_r <= 1'b0;
      rx_done_irq <= 1'b0;
      rx_error_irq <= 1'b0;
    end else begin
      rx_prev_r <= serial_in_pin;
      rx_done_irq <= rx_stop_seen && (!any_err || merge_err);
      rx_error_irq <= rx_stop_seen && any_err && !merge_err;
      if (rx_tick) begin
        rx_half_r <= !rx_half_r;
      end
      case (rx_state_r)
        RX_IDLE: begin
          if (rx_fall) begin
            rx_state_r <= RX_START;
            rx_half_r <= 1'b0;
          end
        end
        RX_START: begin
          if (rx_tick) begin
            rx_state_r <= serial_in_pin ? RX_IDLE : RX_DATA;
            rx_half_r <= 1'b0;
            rx_idx_r <= 4'h0;
            rx_ones_r <= 1'b0;
          end
        end
        RX_DATA: begin
          if (rx_mid) begin
            rx_ones_r <= rx_ones_r ^ serial_in_pin;
            if (rx_idx_r < data_bits(len8)) begin
              receive_shifter_r <= {serial_in_pin, receive_shifter_r[7:1]};
            end
            rx_idx_r <= rx_idx_r + 4'h1;
            if (rx_idx_r == rx_last) begin
              rx_state_r <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_mid) begin
            rx_state_r <= RX_IDLE;
          end
        end
        default: rx_state_r <= RX_IDLE;
      endcase
    end
  end

endmodule // upr_path

// ### verif/upr_node.sv
`timescale 1ns/1ns
module upr_node #(
  parameter DIV = 2
) (
  input wire clk, // Base clock.
  input wire tx_line, // Line from the block.
  output logic rx_line // Line into the block.
);
  // The line has a pull-up, so a released line sits at mark.
  initial rx_line = 1'h1;
  task automatic send(input logic [11:0] f);
    for (int i = 0; i < 12; i++) begin
      rx_line <= f[i];
      repeat (2 * DIV) @(posedge clk);
    end
  endtask
  // Returns mid stop bit so a back-to-back start edge is not missed.
  task automatic catch(input int n, output logic [11:0] f);
    f = 12'hFFF;
    @(negedge tx_line);
    repeat (DIV) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      if (i > 0) repeat (2 * DIV) @(posedge clk);
      f[i] = tx_line;
    end
  endtask
endmodule // upr_node

// ### verif/upr_path_assertions.sv
`timescale 1ns/1ns
module upr_path_chk (
  input wire clk, // Clock.
  input wire rst_n, // Reset.
  input wire avs_read, // Read.
  input wire avs_write, // Write.
  input wire [31:0] avs_readdata, // Read data.
  input wire avs_waitrequest, // Stall.
  input wire serial_out_pin, // Tx line.
  input wire tx_done_irq, // Tx done.
  input wire rx_done_irq, // Rx done.
  input wire rx_error_irq // Rx error.
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // The shortest legal bit is four clocks, since the divisor is at least two.
  sequence s_bit_low;
    !serial_out_pin [*3];
  endsequence
  a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered after one wait cycle");
  a_rd_upper: assert property (avs_readdata[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  a_tx_stop_high: assert property (tx_done_irq |-> $past(serial_out_pin))
    else $error("tx done without a stop level before it");
  a_tx_pulse: assert property (tx_done_irq |=> !tx_done_irq)
    else $error("tx done longer than one cycle");
  a_bit_width: assert property ($fell(serial_out_pin) |=> s_bit_low)
    else $error("low bit on tx line too short");
  a_rx_excl: assert property (!(rx_done_irq && rx_error_irq))
    else $error("rx done and rx error together");
  a_rx_pulse: assert property (rx_done_irq |=> !rx_done_irq [*3])
    else $error("rx done repeated too soon");
  a_err_pulse: assert property (rx_error_irq |=> !rx_error_irq [*3])
    else $error("rx error repeated too soon");
endmodule // upr_path_chk

// ### verif/upr_path_tb.sv
`timescale 1ns/1ns
`include "upr_defs.vh"
module upr_path_tb;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, serial_in_pin, serial_out_pin, tx_done_irq, rx_done_irq, rx_error_irq;
  int fails = 0;
  int cmp_count = 0;
  int n_tx = 0, n_rx = 0, n_err = 0, e_rx = 0, e_err = 0;
  logic [31:0] q;
  logic [11:0] f, g;
  typedef struct packed {logic [1:0] ps; logic [7:0] d; logic pb; logic perr;} upr_row_t;
  upr_row_t rows [6] = '{'{`UPR_PAR_NONE, 8'hA5, 1'h0, 1'h0}, '{`UPR_PAR_ZERO, 8'h07, 1'h0, 1'h0},
    '{`UPR_PAR_ODD, 8'h07, 1'h0, 1'h1}, '{`UPR_PAR_ODD, 8'h55, 1'h1, 1'h1},
    '{`UPR_PAR_EVEN, 8'h07, 1'h1, 1'h1}, '{`UPR_PAR_EVEN, 8'h55, 1'h0, 1'h1}};
  initial begin
    forever #20 clk = ~clk;
  end
  upr_path u_dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .tx_done_irq(tx_done_irq), .rx_done_irq(rx_done_irq), .rx_error_irq(rx_error_irq));
  upr_node #(.DIV(2)) u_node (.clk(clk), .tx_line(serial_out_pin), .rx_line(serial_in_pin));
  always @(posedge clk) begin
    n_tx <= n_tx + (tx_done_irq === 1'h1);
    n_rx <= n_rx + (rx_done_irq === 1'h1);
    n_err <= n_err + (rx_error_irq === 1'h1);
  end
  // ----
  // Bus and check helpers
  // ----
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'h0) @(posedge clk);
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    bus(1'h0, a, 8'h00);
    chk(q, e);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'h1, a, d);
  endtask
  function automatic logic [11:0] mkf(input logic [7:0] d, input logic [1:0] ps, input logic pb, input logic sb);
    mkf = (ps == `UPR_PAR_NONE) ? {2'h3, sb, d, 1'h0} : {1'h1, sb, pb, d, 1'h0};
  endfunction
  task test_done;
    if (fails == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    test_done;
  end
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rd(`UPR_OFS_MODE, 32'h00);
    rd(`UPR_OFS_DIVISOR, 32'h10);
    rd(`UPR_OFS_RXBUF, 32'hFF);
    rd(5'h18, 32'h00);
    wr(`UPR_OFS_TXBUF, 8'h3C);
    rd(`UPR_OFS_TXSTAT, 32'h00);
    wr(`UPR_OFS_DIVISOR, 8'h02);
    wr(`UPR_OFS_MODE, 8'h80);
    foreach (rows[i]) begin
      wr(`UPR_OFS_MODE, 8'hE4 | {rows[i].ps, 3'h0});
      fork
        wr(`UPR_OFS_TXBUF, rows[i].d);
        u_node.catch(rows[i].ps == `UPR_PAR_NONE ? 10 : 11, f);
      join
      chk(f, mkf(rows[i].d, rows[i].ps, rows[i].pb, 1'h1));
      repeat (8) @(posedge clk);
      chk(n_tx, i + 1);
      rd(`UPR_OFS_TXSTAT, 32'h00);
      u_node.send(mkf(rows[i].d, rows[i].ps, rows[i].pb, 1'h1));
      rd(`UPR_OFS_ERRSTAT, 32'h00);
      rd(`UPR_OFS_RXBUF, rows[i].d);
      u_node.send(mkf(rows[i].d, rows[i].ps, !rows[i].pb, 1'h1));
      e_rx += 1 + !rows[i].perr;
      e_err += rows[i].perr;
      rd(`UPR_OFS_ERRSTAT, {rows[i].perr, 2'h0});
      rd(`UPR_OFS_RXBUF, rows[i].d);
      chk(n_err, e_err);
    end
    fork
      begin
        wr(`UPR_OFS_TXBUF, 8'h01);
        rd(`UPR_OFS_TXSTAT, 32'h01);
        wr(`UPR_OFS_TXBUF, 8'h02);
        rd(`UPR_OFS_TXSTAT, 32'h03);
      end
      begin
        u_node.catch(11, f);
        u_node.catch(11, g);
      end
    join
    chk(f, mkf(8'h01, `UPR_PAR_EVEN, 1'h1, 1'h1));
    chk(g, mkf(8'h02, `UPR_PAR_EVEN, 1'h1, 1'h1));
    repeat (8) @(posedge clk);
    rd(`UPR_OFS_TXSTAT, 32'h00);
    chk(n_tx, 8);
    // Two stop bits and merged errors; the receiver still checks only one stop.
    wr(`UPR_OFS_MODE, 8'hFF);
    u_node.send(mkf(8'h55, `UPR_PAR_EVEN, 1'h0, 1'h0));
    rd(`UPR_OFS_ERRSTAT, 32'h02);
    rd(`UPR_OFS_ERRSTAT, 32'h00);
    rd(`UPR_OFS_RXBUF, 8'h55);
    u_node.send(mkf(8'h11, `UPR_PAR_EVEN, 1'h0, 1'h1));
    u_node.send(mkf(8'h22, `UPR_PAR_EVEN, 1'h0, 1'h1));
    rd(`UPR_OFS_ERRSTAT, 32'h01);
    rd(`UPR_OFS_RXBUF, 8'h11);
    chk(n_rx, e_rx + 3);
    chk(n_err, e_err);
    // Seven data bits, odd parity and two stop bits in both directions.
    wr(`UPR_OFS_MODE, 8'hF2);
    fork
      wr(`UPR_OFS_TXBUF, 8'h36);
      u_node.catch(11, f);
    join
    chk(f, {4'hF, 7'h36, 1'h0});
    repeat (8) @(posedge clk);
    chk(n_tx, 9);
    u_node.send({4'hF, 7'h36, 1'h0});
    rd(`UPR_OFS_ERRSTAT, 32'h00);
    rd(`UPR_OFS_RXBUF, 32'h36);
    // A second reset in mid-run must bring back the mode, both status and receive buffer values.
    rst_n <= 1'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rd(`UPR_OFS_MODE, 32'h00);
    rd(`UPR_OFS_ERRSTAT, 32'h00);
    rd(`UPR_OFS_TXSTAT, 32'h00);
    rd(`UPR_OFS_RXBUF, 32'hFF);
    test_done;
  end
endmodule // upr_path_tb
bind upr_path upr_path_chk u_chk (.clk(clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .serial_out_pin(serial_out_pin),
  .tx_done_irq(tx_done_irq), .rx_done_irq(rx_done_irq), .rx_error_irq(rx_error_irq));
